// ==== t2of_top.sv ====
// Purpose: Timer 2 overflow flags, control register and interrupt request.
// Assumes: Wrap strobes are one-cycle pulses from same-clock counter logic.
// Notes:   One-wait-state Avalon-MM slave; unmapped reads return zero.
module t2of_top (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [t2of_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [t2of_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [t2of_pkg::DATA_W-1:0] avs_readdata,
    output logic                            avs_waitrequest,
    input  wire t2of_pkg::t2of_wrap_t       wrap,
    input  wire logic                       timer2_irq_enable,
    output t2of_pkg::t2of_cfg_t             cfg,
    output logic                            timer2_irq_request,
    output logic                            irq
);
    import t2of_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    t2of_ctrl_t             ctrl;
    t2of_ctrl_t             next_ctrl;
    logic [EVT_W-1:0]       evt_stat;
    logic [EVT_W-1:0]       next_evt_stat;
    logic [EVT_W-1:0]       evt_mask;
    logic                   served;
    logic [DATA_W-1:0]      next_readdata;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Every access takes one wait state, so the answer stands at the
    // second edge of the request; the readdata flop is loaded at the first.
    wire logic              req        = avs_read | avs_write;
    wire logic              wr_take    = avs_write & served & avs_byteenable[0];
    wire logic              hit_ctrl   = (avs_address == OFF_CONTROL);
    wire logic              hit_stat   = (avs_address == OFF_EVT_STAT);
    wire logic              hit_mask   = (avs_address == OFF_EVT_MASK);
    wire logic              hit_bitop  = (avs_address == OFF_BIT_OP);
    wire logic              wr_ctrl    = wr_take & hit_ctrl;
    wire logic              wr_stat    = wr_take & hit_stat;
    wire logic              wr_mask    = wr_take & hit_mask;
    wire logic              wr_bitop   = wr_take & hit_bitop;
    wire logic [2:0]        bit_idx    = avs_writedata[BITOP_IDX_MSB:BITOP_IDX_LSB];
    wire logic              bit_val    = avs_writedata[BITOP_VAL];

    assign avs_waitrequest = req & ~served;

    // ------------------------------------------------------------
    // Mode and flag sources
    // ------------------------------------------------------------
    wire t2of_mode_t        mode       = ctrl.split_mode_select ? T2OF_MODE_SPLIT
                                                                : T2OF_MODE_16BIT;
    // In 16-bit mode the counter logic only pulses the upper wrap when the
    // whole count rolls over, so one strobe serves both arrangements.
    wire logic              set_high   = wrap.high_byte_wrap;
    // The lower wrap sets its flag whatever the mode.
    wire logic              set_low    = wrap.low_byte_wrap;

    // Single-bit image applied to the control register by a bit operation.
    function automatic logic [REG_W-1:0] bit_apply(input logic [REG_W-1:0] cur,
                                                   input logic [2:0]       idx,
                                                   input logic             val);
        logic [REG_W-1:0] res;
        res      = cur;
        res[idx] = val;
        return res;
    endfunction : bit_apply

    // ------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = t2of_ctrl_t'(avs_writedata[REG_W-1:0]);
        end else if (wr_bitop) begin
            next_ctrl = t2of_ctrl_t'(bit_apply(ctrl, bit_idx, bit_val));
        end
        // Only software writes can lower a flag; hardware merely sets it.
        next_ctrl.unused = 1'b0;
        if (set_high) begin
            next_ctrl.high_byte_overflow_flag = 1'b1;
        end
        if (set_low) begin
            next_ctrl.low_byte_overflow_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Event status (sticky, write one to clear), set beats clear
    // ------------------------------------------------------------
    wire logic [EVT_W-1:0]  evt_set    = {set_low, set_high};
    wire logic [EVT_W-1:0]  evt_clr    = wr_stat ? avs_writedata[EVT_W-1:0] : RST_EVT;

    assign next_evt_stat = (evt_stat & ~evt_clr) | evt_set;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        next_readdata = READ_ZERO;
        if (hit_ctrl) begin
            next_readdata[REG_W-1:0] = ctrl;
        end else if (hit_stat) begin
            next_readdata[EVT_W-1:0] = evt_stat;
        end else if (hit_mask) begin
            next_readdata[EVT_W-1:0] = evt_mask;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            served <= 1'b0;
        end else begin
            served <= req & ~served;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= READ_ZERO;
        end else if (avs_read & ~served) begin
            avs_readdata <= next_readdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= t2of_ctrl_t'(RST_CONTROL);
            evt_stat <= RST_EVT;
        end else begin
            ctrl     <= next_ctrl;
            evt_stat <= next_evt_stat;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_mask <= RST_EVT;
        end else if (wr_mask) begin
            evt_mask <= avs_writedata[EVT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cfg.comparator_capture_enable = ctrl.comparator_capture_enable;
    assign cfg.split_mode_select         = (mode == T2OF_MODE_SPLIT);
    assign cfg.timer_run_control         = ctrl.timer_run_control;
    assign cfg.external_clock_select     = ctrl.external_clock_select;

    // The request is a level that follows the flags and enables, so it stays up until
    // software clears the flag (or low_byte_irq_enable, for the low flag only), or timer2_irq_enable falls.
    assign timer2_irq_request = timer2_irq_enable &
                                (ctrl.high_byte_overflow_flag |
                                 (ctrl.low_byte_irq_enable &
                                  ctrl.low_byte_overflow_flag));

    assign irq = |(evt_stat & evt_mask);

endmodule : t2of_top

// ==== t2of_pkg.sv ====
// Purpose: Shared constants and types for the Timer 2 overflow-flag block.
// Assumes: Avalon-MM register bus, 32-bit data, byte addresses.
// Notes:   Control register layout is kept as a packed struct.
// Notes on behaviour
// - Upper byte wrap sets high overflow flag.
// - In 16-bit mode full wrap sets high flag.
// - High flag with enable raises interrupt request.
// - Lower byte wrap sets low overflow flag.
// - Low flag set in every counter mode.
// - Flags clear only by software writing zero.
// - Control bit 5 enables low-byte interrupt.
// - Control register page-free, single-bit set/clear access.
// - Low overflow with both enables raises request.
// - Split select: zero 16-bit, one two 8-bit.
package t2of_pkg;

    // ------------------------------------------------------------
    // Bus geometry and register map
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;

    localparam logic [7:0]  OFF_CONTROL   = 8'hc8;
    localparam logic [7:0]  OFF_EVT_STAT  = 8'hcc;
    localparam logic [7:0]  OFF_EVT_MASK  = 8'hd0;
    localparam logic [7:0]  OFF_BIT_OP    = 8'hd4;

    localparam logic [7:0]  RST_CONTROL   = 8'h00;
    localparam logic [1:0]  RST_EVT       = 2'h0;
    localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

    // Bit-operation register: bit index in [2:0], value in [3].
    localparam int          BITOP_IDX_LSB = 0;
    localparam int          BITOP_IDX_MSB = 2;
    localparam int          BITOP_VAL     = 3;

    // Event status / mask layout.
    localparam int          EVT_HIGH      = 0;
    localparam int          EVT_LOW       = 1;
    localparam int          EVT_W         = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic high_byte_overflow_flag;
        logic low_byte_overflow_flag;
        logic low_byte_irq_enable;
        logic comparator_capture_enable;
        logic split_mode_select;
        logic timer_run_control;
        logic unused;
        logic external_clock_select;
    } t2of_ctrl_t;

    typedef struct packed {
        logic high_byte_wrap;
        logic low_byte_wrap;
    } t2of_wrap_t;

    typedef struct packed {
        logic comparator_capture_enable;
        logic split_mode_select;
        logic timer_run_control;
        logic external_clock_select;
    } t2of_cfg_t;

    typedef enum logic {
        T2OF_MODE_16BIT,
        T2OF_MODE_SPLIT
    } t2of_mode_t;

endpackage : t2of_pkg

// ==== t2of_assertions.sv ====
// Purpose: Port-level checks of the Timer 2 overflow-flag block.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to every instance of the top module.
module t2of_assertions (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic [t2of_pkg::ADDR_W-1:0] avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [t2of_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0]                  avs_byteenable,
    input wire logic [t2of_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                        avs_waitrequest,
    input wire t2of_pkg::t2of_wrap_t        wrap,
    input wire logic                        timer2_irq_enable,
    input wire t2of_pkg::t2of_cfg_t         cfg,
    input wire logic                        timer2_irq_request,
    input wire logic                        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import t2of_pkg::*;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence req_open;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence high_wrap_seen;
        wrap.high_byte_wrap ##1 timer2_irq_enable;
    endsequence
    wait_one_a: assert property (req_open |=> !avs_waitrequest)
        else $error("bus answer missing after one wait state");
    idle_wait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("wait request raised while bus idle");
    high_req_a: assert property (high_wrap_seen |-> timer2_irq_request)
        else $error("high wrap did not raise request");
    req_gate_a: assert property (!timer2_irq_enable |-> !timer2_irq_request)
        else $error("request without interrupt enable");
    req_hold_a: assert property (timer2_irq_request && !avs_write ##1 timer2_irq_enable
        |-> timer2_irq_request)
        else $error("request dropped without software write");
    irq_hold_a: assert property (irq && !avs_write |=> irq)
        else $error("irq dropped without software write");
    cfg_hold_a: assert property (!avs_write |=> $stable(cfg))
        else $error("configuration changed without write");
    rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed outside a read");
    rdata_upper_a: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[DATA_W-1:REG_W] == '0)
        else $error("read data upper bits not zero");
endmodule : t2of_assertions

bind t2of_top t2of_assertions t2of_assertions_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wrap(wrap),
    .timer2_irq_enable(timer2_irq_enable), .cfg(cfg),
    .timer2_irq_request(timer2_irq_request), .irq(irq));

// ==== t2of_bench.sv ====
// Purpose: Self-checking bench for the Timer 2 overflow-flag block.
// Assumes: One wait state per bus access, wrap strobes one cycle long.
// Notes:   Random control words and wraps come from a fixed xorshift seed.
module t2of_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import t2of_pkg::*;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, timer2_irq_enable;
    logic timer2_irq_request, irq;
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q, d, w, e;
    logic [31:0] seed = 32'h46;
    t2of_wrap_t wrap;
    t2of_cfg_t cfg;
    int num_errors = 0;
    int num_checks = 0;
    t2of_top t2of_top_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .wrap(wrap), .timer2_irq_enable(timer2_irq_enable),
        .cfg(cfg), .timer2_irq_request(timer2_irq_request), .irq(irq));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #4 clk = ~clk;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Holds the request until waitrequest is seen low at a rising edge, or for at most 20 edges.
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) num_errors++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
    task rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd
    task pulse(input logic [1:0] p);
        @(posedge clk);
        wrap <= t2of_wrap_t'(p);
        @(posedge clk);
        wrap <= t2of_wrap_t'(2'h0);
        @(posedge clk);
    endtask : pulse
    task test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    initial begin
        clk = 0; rst_n = 0; avs_address = 0; avs_read = 0; avs_write = 0;
        avs_writedata = 0; avs_byteenable = 4'hf; wrap = 0; timer2_irq_enable = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_CONTROL, 32'h0);
        rd(8'he0, READ_ZERO);
        avs_byteenable <= 4'he;
        xfer(1'b1, OFF_CONTROL, 32'hff);
        avs_byteenable <= 4'hf;
        rd(OFF_CONTROL, 32'h0);
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            w = rnd();
            timer2_irq_enable <= d[9];
            xfer(1'b1, OFF_CONTROL, {24'h0, d[7:0]});
            pulse(w[1:0]);
            e = {24'h0, d[7:0] & 8'hfd} | {24'h0, w[1], w[0], 6'h0};
            rd(OFF_CONTROL, e);
            check(cfg, {e[4], e[3], e[2], e[0]});
            check(timer2_irq_request, d[9] & (e[7] | (e[5] & e[6])));
        end
        xfer(1'b1, OFF_CONTROL, 32'h0);
        timer2_irq_enable <= 1'b1;
        wrap <= t2of_wrap_t'(2'h2);
        xfer(1'b1, OFF_CONTROL, 32'h0);
        wrap <= t2of_wrap_t'(2'h0);
        repeat (40) @(posedge clk);
        rd(OFF_CONTROL, 32'h80);
        check(timer2_irq_request, 1'b1);
        xfer(1'b1, OFF_BIT_OP, 32'h7);
        xfer(1'b1, OFF_BIT_OP, 32'hd);
        pulse(2'h1);
        rd(OFF_CONTROL, 32'h60);
        check(timer2_irq_request, 1'b1);
        xfer(1'b1, OFF_EVT_STAT, 32'h3);
        rd(OFF_EVT_STAT, 32'h0);
        xfer(1'b1, OFF_EVT_MASK, 32'h2);
        pulse(2'h2);
        check(irq, 1'b0);
        pulse(2'h1);
        check(irq, 1'b1);
        rd(OFF_EVT_STAT, 32'h3);
        xfer(1'b1, OFF_EVT_STAT, 32'h2);
        @(posedge clk);
        check(irq, 1'b0);
        test_done();
    end
endmodule : t2of_bench
